// ==== aos_scaler.v ====
// Purpose: analog output source select and scaling to percent of full scale
// Assumes: source inputs synchronous to clk; setpoint unit is 0.01 percent
// Notes: results queue in a 16 word fifo ahead of the converter stage
// Notes on behaviour
// - position error source outputs commanded minus feedback position continuously.
// - commanded velocity source outputs the commanded velocity, no feedback used.
// - measured velocity source outputs the feedback sensor velocity.
// - fast-capable drive sources refresh every 250 us instead of 4 ms when in high-speed mode.
// - fast refresh only with fast-capable source and high-speed mode together.
// - drive parameter selector is menu and parameter, range 0.00 to 21.51.
// - drive parameter output is value over its maximum times the scale.
// - drive parameter source bypasses min and max interpolation settings.
// - source at maximum value gives maximum output percentage.
// - source at minimum value gives minimum output; linear in between.
// - calibration points are line points, not limits on the source.
// - four output modes, 0-20 mA, 4-20 mA, high speed 9.8 V, 10 V.
// - high-speed mode with a fast-capable source uses fixed scaling: max speed, rated current over 0.45.
// - high-speed power full scale is rated current over 0.45 times max bus.
// - drive speed source is always in rpm.
// - output power is drive output voltage times active current, in kW.
// - module variable source goes through min and max interpolation.
// - with channel disabled nothing is sent to the converter stage.
`timescale 1ns/10ps
`include "aos_map.vh"
module aos_scaler #(
	parameter [17:0] SLOW_CYCLES = `AOS_SLOW_US * `AOS_CLK_MHZ,
	parameter [17:0] FAST_CYCLES = `AOS_FAST_US * `AOS_CLK_MHZ
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	// motion values
	input wire signed [31:0] commanded_position,
	input wire signed [31:0] feedback_position,
	input wire signed [31:0] commanded_velocity_value,
	input wire signed [31:0] measured_velocity_value,
	input wire signed [31:0] module_var,
	// drive values
	input wire signed [15:0] speed_rpm,
	input wire signed [15:0] active_current,
	input wire signed [15:0] reactive_current,
	input wire signed [15:0] output_voltage,
	input wire [15:0] max_speed,
	input wire [15:0] rated_current,
	input wire [15:0] max_bus_voltage,
	// drive parameter lookup
	output reg [7:0] param_menu,
	output reg [7:0] param_num,
	input wire signed [31:0] param_value,
	input wire [31:0] param_max,
	// converter stage
	output reg dac_valid,
	input wire dac_ready,
	output reg [15:0] dac_data,
	output reg [1:0] dac_mode
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_DIV = 3'b010;
	localparam [2:0] ST_PUSH = 3'b100;
	localparam [15:0] RST_MENU = `AOS_RST_MENU;

	function is_fast;
		input [3:0] sel;
		begin
			is_fast = (sel == `AOS_SRC_SPEED) || (sel == `AOS_SRC_ACTCUR) ||
				(sel == `AOS_SRC_REACUR) || (sel == `AOS_SRC_POWER);
		end
	endfunction

	function [15:0] sat_pct;
		input signed [63:0] v;
		begin
			if (v < 64'sd0)
				sat_pct = 16'h0000;
			else if (v > $signed({48'h0, `AOS_FULL}))
				sat_pct = `AOS_FULL;
			else
				sat_pct = v[15:0];
		end
	endfunction

	function sel_ok;
		input [7:0] menu;
		input [7:0] prm;
		begin
			if (menu > `AOS_MENU_LAST)
				sel_ok = 1'b0;
			else if (menu == `AOS_MENU_LAST)
				sel_ok = prm <= `AOS_PARAM_LAST_MENU;
			else
				sel_ok = prm <= `AOS_PARAM_LAST;
		end
	endfunction

	// control registers
	reg [9:0] ctrl;
	reg [15:0] scale;
	reg signed [31:0] max_val;
	reg signed [31:0] min_val;
	reg signed [15:0] max_out;
	reg signed [15:0] min_out;
	reg sel_err;
	reg [15:0] last_out;
	wire en = ctrl[`AOS_CTRL_EN];
	wire [3:0] src_sel = ctrl[`AOS_CTRL_SRC_MSB:`AOS_CTRL_SRC_LSB];
	wire [1:0] mode = ctrl[`AOS_CTRL_MODE_MSB:`AOS_CTRL_MODE_LSB];
	wire fast = is_fast(src_sel) && (mode == `AOS_MODE_HS);

	// compute state
	reg [2:0] state;
	reg [17:0] tick_cnt;
	reg signed [63:0] lat_num;
	reg signed [63:0] lat_den;
	reg signed [63:0] lat_off;
	reg div_start;
	reg [15:0] result;
	wire div_done;
	wire signed [63:0] div_quo;

	// fifo wiring
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [15:0] fifo_out_data;
	wire [4:0] fifo_level;
	wire take = en && (!dac_valid || dac_ready);

	// source selection and scaling terms
	reg signed [31:0] src;
	reg signed [31:0] power_w;
	reg signed [63:0] power_kw;
	reg signed [63:0] wide_a;
	reg signed [63:0] wide_b;
	reg signed [63:0] next_num;
	reg signed [63:0] next_den;
	reg signed [63:0] next_off;

	always @* begin
		power_w = $signed({{16{output_voltage[15]}}, output_voltage}) *
			$signed({{16{active_current[15]}}, active_current});
		power_kw = ($signed({{32{power_w[31]}}, power_w}) *
			$signed({48'h0, `AOS_KW_MUL})) >>> `AOS_KW_SHIFT;
		case (src_sel)
			`AOS_SRC_POSERR: src = commanded_position - feedback_position;
			`AOS_SRC_CMDVEL: src = commanded_velocity_value;
			`AOS_SRC_MEASVEL: src = measured_velocity_value;
			`AOS_SRC_MODVAR: src = module_var;
			`AOS_SRC_SPEED: src = {{16{speed_rpm[15]}}, speed_rpm};
			`AOS_SRC_ACTCUR: src = {{16{active_current[15]}}, active_current};
			`AOS_SRC_REACUR: src = {{16{reactive_current[15]}}, reactive_current};
			`AOS_SRC_POWER: src = power_kw[31:0];
			`AOS_SRC_PARAM: src = param_value;
			default: src = 32'h0;
		endcase
		wide_a = 64'h0;
		wide_b = 64'h0;
		next_off = 64'h0;
		if (fast) begin
			// fixed full scale, user points ignored
			case (src_sel)
				`AOS_SRC_SPEED: begin
					wide_a = {{32{src[31]}}, src};
					next_num = wide_a * $signed({48'h0, `AOS_FULL});
					next_den = {48'h0, max_speed};
				end
				`AOS_SRC_POWER: begin
					wide_a = {{32{power_w[31]}}, power_w};
					next_num = wide_a * $signed({48'h0, `AOS_HS_GAIN});
					next_den = {32'h0, {16'h0, rated_current} * {16'h0, max_bus_voltage}};
				end
				default: begin
					wide_a = {{32{src[31]}}, src};
					next_num = wide_a * $signed({48'h0, `AOS_HS_GAIN});
					next_den = {48'h0, rated_current};
				end
			endcase
		end else if (src_sel == `AOS_SRC_PARAM) begin
			// value over its maximum times scale, no min/max points
			wide_a = {{32{param_value[31]}}, param_value};
			wide_b = $signed({48'h0, scale});
			next_num = wide_a * wide_b * $signed({48'h0, `AOS_SCALE_UNIT});
			next_den = {32'h0, param_max};
		end else begin
			// line through (min_val,min_out) and (max_val,max_out)
			wide_a = {{32{src[31]}}, src};
			wide_b = {{32{min_val[31]}}, min_val};
			next_num = (wide_a - wide_b);
			wide_b = {{48{max_out[15]}}, max_out} - {{48{min_out[15]}}, min_out};
			next_num = next_num * wide_b;
			wide_a = {{32{max_val[31]}}, max_val};
			wide_b = {{32{min_val[31]}}, min_val};
			next_den = wide_a - wide_b;
			next_off = {{48{min_out[15]}}, min_out};
		end
	end

	// register port
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `AOS_RST_CTRL;
			param_menu <= RST_MENU[15:8];
			param_num <= RST_MENU[7:0];
			scale <= `AOS_RST_SCALE;
			max_val <= `AOS_RST_MAXV;
			min_val <= `AOS_RST_MINV;
			max_out <= `AOS_RST_MAXO;
			min_out <= `AOS_RST_MINO;
			sel_err <= 1'b0;
			rdata <= 32'h0;
		end else begin
			if (wr) begin
				case (addr)
					`AOS_OFF_CTRL: ctrl <= wdata[9:0];
					`AOS_OFF_MENU: begin
						if (sel_ok(wdata[15:8], wdata[7:0])) begin
							param_menu <= wdata[15:8];
							param_num <= wdata[7:0];
							sel_err <= 1'b0;
						end else begin
							sel_err <= 1'b1;
						end
					end
					`AOS_OFF_SCALE: scale <= wdata[15:0];
					`AOS_OFF_MAXV: max_val <= wdata;
					`AOS_OFF_MINV: min_val <= wdata;
					`AOS_OFF_MAXO: max_out <= wdata[15:0];
					`AOS_OFF_MINO: min_out <= wdata[15:0];
					default: ;
				endcase
			end
			rdata <= 32'h0;
			if (rd) begin
				case (addr)
					`AOS_OFF_CTRL: rdata <= {22'h0, ctrl};
					`AOS_OFF_MENU: rdata <= {16'h0, param_menu, param_num};
					`AOS_OFF_SCALE: rdata <= {16'h0, scale};
					`AOS_OFF_MAXV: rdata <= max_val;
					`AOS_OFF_MINV: rdata <= min_val;
					`AOS_OFF_MAXO: rdata <= {{16{max_out[15]}}, max_out};
					`AOS_OFF_MINO: rdata <= {{16{min_out[15]}}, min_out};
					`AOS_OFF_STAT: rdata <= {19'h0, fifo_level, 4'h0, sel_err, fast,
						state != ST_IDLE, en};
					`AOS_OFF_LAST: rdata <= {16'h0, last_out};
					default: rdata <= 32'h0;
				endcase
			end
		end
	end

	// refresh timer, period picked by source and mode
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= 18'h0;
		end else if (!en || tick_cnt >= (fast ? FAST_CYCLES : SLOW_CYCLES) - 18'h1) begin
			tick_cnt <= 18'h0;
		end else begin
			tick_cnt <= tick_cnt + 18'h1;
		end
	end
	wire tick = en && (tick_cnt >= (fast ? FAST_CYCLES : SLOW_CYCLES) - 18'h1);

	// sample, divide, queue
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			lat_num <= 64'h0;
			lat_den <= 64'h0;
			lat_off <= 64'h0;
			div_start <= 1'b0;
			result <= 16'h0;
			last_out <= 16'h0;
		end else begin
			div_start <= 1'b0;
			if (!en) begin
				state <= ST_IDLE;
			end else begin
				case (state)
					ST_IDLE: begin
						if (tick) begin
							lat_num <= next_num;
							lat_den <= next_den;
							lat_off <= next_off;
							if (next_den == 64'h0) begin
								result <= sat_pct(next_off);
								state <= ST_PUSH;
							end else begin
								div_start <= 1'b1;
								state <= ST_DIV;
							end
						end
					end
					ST_DIV: begin
						if (div_done) begin
							result <= sat_pct(div_quo + lat_off);
							state <= ST_PUSH;
						end
					end
					ST_PUSH: begin
						// waits here while the queue is full
						if (fifo_in_ready) begin
							last_out <= result;
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// converter stage holding register
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dac_valid <= 1'b0;
			dac_data <= 16'h0;
			dac_mode <= `AOS_MODE_I020;
		end else begin
			dac_mode <= mode;
			if (!en) begin
				dac_valid <= 1'b0;
			end else if (take) begin
				dac_valid <= fifo_out_valid;
				if (fifo_out_valid)
					dac_data <= fifo_out_data;
			end
		end
	end

	aos_sdiv u_div (
		.clk(clk),
		.rst_b(rst_b),
		.start(div_start),
		.num(lat_num),
		.den(lat_den),
		.done(div_done),
		.quo(div_quo)
	);

	aos_fifo #(
		.WIDTH(16),
		.DEPTH(16),
		.AW(4)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.flush(!en),
		.in_valid(en && state == ST_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(result),
		.out_valid(fifo_out_valid),
		.out_ready(take),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);
endmodule // aos_scaler

// ==== aos_map.vh ====
// Purpose: offsets, fields, reset values and timing of the output source scaler
// Assumes: 40 MHz clock, setpoints in hundredths of a percent of full scale
// Notes: definitions only
`ifndef AOS_MAP_VH
`define AOS_MAP_VH
// register offsets
`define AOS_OFF_CTRL 8'h00
`define AOS_OFF_MENU 8'h04
`define AOS_OFF_SCALE 8'h08
`define AOS_OFF_MAXV 8'h0c
`define AOS_OFF_MINV 8'h10
`define AOS_OFF_MAXO 8'h14
`define AOS_OFF_MINO 8'h18
`define AOS_OFF_STAT 8'h1c
`define AOS_OFF_LAST 8'h20
// control fields
`define AOS_CTRL_EN 0
`define AOS_CTRL_SRC_LSB 4
`define AOS_CTRL_SRC_MSB 7
`define AOS_CTRL_MODE_LSB 8
`define AOS_CTRL_MODE_MSB 9
// status fields
`define AOS_STAT_EN 0
`define AOS_STAT_BUSY 1
`define AOS_STAT_FAST 2
`define AOS_STAT_SELERR 3
`define AOS_STAT_LVL_LSB 8
`define AOS_STAT_LVL_MSB 12
// reset values
`define AOS_RST_CTRL 10'h000
`define AOS_RST_MENU 16'h0000
`define AOS_RST_SCALE 16'h0064
`define AOS_RST_MAXV 32'h00001388
`define AOS_RST_MINV 32'hffffec78
`define AOS_RST_MAXO 16'h2710
`define AOS_RST_MINO 16'h0000
// source codes
`define AOS_SRC_POSERR 4'h0
`define AOS_SRC_CMDVEL 4'h1
`define AOS_SRC_MEASVEL 4'h2
`define AOS_SRC_MODVAR 4'h3
`define AOS_SRC_PARAM 4'h4
`define AOS_SRC_SPEED 4'h5
`define AOS_SRC_ACTCUR 4'h6
`define AOS_SRC_REACUR 4'h7
`define AOS_SRC_POWER 4'h8
// output modes
`define AOS_MODE_I020 2'h0
`define AOS_MODE_I420 2'h1
`define AOS_MODE_HS 2'h2
`define AOS_MODE_V10 2'h3
// scaling constants
`define AOS_FULL 16'h2710
`define AOS_HS_GAIN 16'h1194
`define AOS_SCALE_UNIT 16'h0064
`define AOS_KW_MUL 16'h0419
`define AOS_KW_SHIFT 20
`define AOS_MENU_LAST 8'h15
`define AOS_PARAM_LAST_MENU 8'h33
`define AOS_PARAM_LAST 8'h63
// timing
`define AOS_CLK_MHZ 40
`define AOS_SLOW_US 4000
`define AOS_FAST_US 250
`endif

// ==== aos_fifo.v ====
// Purpose: setpoint queue between the scaler and the converter stage
// Assumes: one clock, synchronous flush
// Notes: full and empty come from pointers one bit wider than the address
`timescale 1ns/10ps
module aos_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire flush,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign level = wr_ptr - rd_ptr;

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // aos_fifo

// ==== aos_sdiv.v ====
// Purpose: signed 64 by 64 bit divide, quotient truncated toward zero
// Assumes: caller never starts with a zero divisor
// Notes: one quotient bit per clock, done pulses after 64 steps
`timescale 1ns/10ps
module aos_sdiv (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// request
	input wire start,
	input wire signed [63:0] num,
	input wire signed [63:0] den,
	// answer
	output reg done,
	output reg signed [63:0] quo
);
	reg [63:0] dvd;
	reg [63:0] dvs;
	reg [64:0] rem;
	reg neg;
	reg run;
	reg [6:0] step;
	wire [64:0] trial = {rem[63:0], dvd[63]};
	wire fits = trial >= {1'b0, dvs};

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dvd <= 64'h0;
			dvs <= 64'h0;
			rem <= 65'h0;
			neg <= 1'b0;
			run <= 1'b0;
			step <= 7'h00;
			done <= 1'b0;
			quo <= 64'h0;
		end else begin
			done <= 1'b0;
			if (start && !run) begin
				dvd <= num[63] ? -num : num;
				dvs <= den[63] ? -den : den;
				neg <= num[63] ^ den[63];
				rem <= 65'h0;
				step <= 7'h00;
				run <= 1'b1;
			end else if (run) begin
				rem <= fits ? trial - {1'b0, dvs} : trial;
				dvd <= {dvd[62:0], fits};
				step <= step + 7'h01;
				if (step == 7'h3f) begin
					run <= 1'b0;
					done <= 1'b1;
					quo <= neg ? -$signed({dvd[62:0], fits}) : $signed({dvd[62:0], fits});
				end
			end
		end
	end
endmodule // aos_sdiv

// ==== aos_scaler_monitor.sv ====
// Purpose: port checker for the output source scaler
// Assumes: one clock, reset active low, bench keeps control writes apart
// Notes: helpers track enable and selector state from register writes
`timescale 1ns/10ps
module aos_scaler_monitor (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	// parameter lookup
	input wire [7:0] param_menu,
	input wire [7:0] param_num,
	// converter stage
	input wire dac_valid,
	input wire dac_ready,
	input wire [15:0] dac_data,
	input wire [1:0] dac_mode
);
	reg en_q;
	reg bad_q;
	wire menu_wr = wr && addr == 8'h04;
	wire bad_sel = wdata[15:8] > 8'h15 || wdata[7:0] > 8'h63
		|| (wdata[15:8] == 8'h15 && wdata[7:0] > 8'h33);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			if (wr && addr == 8'h00)
				en_q <= wdata[0];
			if (menu_wr)
				bad_q <= bad_sel;
		end
	end
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	dac_hold_a: assert property (dac_valid && !dac_ready |=> !dac_valid || $stable(dac_data))
		else $error("setpoint changed while stalled");
	dac_range_a: assert property (dac_valid |-> dac_data <= 16'h2710)
		else $error("setpoint above full scale");
	mode_copy_a: assert property (wr && addr == 8'h00 |-> ##3 dac_mode == $past(wdata[9:8], 3))
		else $error("output mode not copied");
	param_take_a: assert property (menu_wr && !bad_sel
		|=> ##1 {param_menu, param_num} == $past(wdata[15:0], 2))
		else $error("valid selector not taken");
	param_keep_a: assert property (menu_wr && bad_sel
		|=> ##1 {param_menu, param_num} == $past({param_menu, param_num}, 2))
		else $error("invalid selector taken");
	quiet_off_a: assert property (!en_q && !$past(en_q) |-> !dac_valid)
		else $error("setpoint offered while disabled");
	selerr_flag_a: assert property ($past(rd) && $past(addr) == 8'h1c |-> rdata[3] == bad_q)
		else $error("selector error flag wrong");
endmodule // aos_scaler_monitor

// ==== aos_dac_model.sv ====
// Purpose: behavioural converter stage taking setpoints from the scaler
// Assumes: bench may stall it to back up the queue
// Notes: ready is registered so it only moves just after a clock edge
`timescale 1ns/10ps
module aos_dac_model (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// bench control
	input wire stall,
	// converter link
	input wire dac_valid,
	output reg dac_ready
);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			dac_ready <= 1'b0;
		else
			dac_ready <= !stall;
	end
endmodule // aos_dac_model

// ==== aos_scaler_test.sv ====
// Purpose: register driven test of the output source scaler
// Assumes: short refresh periods of 400 and 100 cycles
// Notes: each check takes the second setpoint after a change
`timescale 1ns/10ps
module aos_scaler_test;
	logic clk, rst_b, wr, rd, stall, dac_valid, dac_ready;
	logic [7:0] addr, param_menu, param_num;
	logic [31:0] wdata, rdata, d, param_max;
	logic signed [31:0] commanded_position, feedback_position, module_var, param_value;
	logic signed [31:0] commanded_velocity_value, measured_velocity_value;
	logic signed [15:0] speed_rpm, active_current, reactive_current, output_voltage;
	logic [15:0] max_speed, rated_current, max_bus_voltage, dac_data, x;
	logic [1:0] dac_mode;
	int failures, n_compared, cyc, gap, t, i, k;
	aos_scaler #(.SLOW_CYCLES(18'd400), .FAST_CYCLES(18'd100)) u_dut (.clk, .rst_b, .addr,
		.wdata, .wr, .rd, .rdata, .commanded_position, .feedback_position,
		.commanded_velocity_value, .measured_velocity_value, .module_var, .speed_rpm,
		.active_current, .reactive_current, .output_voltage, .max_speed, .rated_current,
		.max_bus_voltage, .param_menu, .param_num, .param_value, .param_max, .dac_valid,
		.dac_ready, .dac_data, .dac_mode);
	aos_dac_model u_dac (.clk, .rst_b, .stall, .dac_valid, .dac_ready);
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task conclude;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr_reg(input [7:0] a, input [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_reg(input [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task take;
		for (k = 0; k < 20000; k++) begin
			@(posedge clk);
			#1;
			if (dac_valid === 1'b1 && dac_ready === 1'b1)
				break;
		end
		if (k == 20000) begin
			failures++;
			conclude;
		end
		x = dac_data;
	endtask
	task run(input [31:0] c, input signed [31:0] mv, input [15:0] e);
		@(posedge clk);
		module_var <= mv;
		wr_reg(8'h00, c);
		take;
		t = cyc;
		take;
		gap = cyc - t;
		chk("setpoint", x, e);
	endtask
	initial begin
		{rst_b, wr, rd, stall, addr, wdata} = 0;
		{commanded_position, feedback_position} = {32'sd3000, 32'sd1000};
		{commanded_velocity_value, measured_velocity_value} = {-32'sd5000, 32'sd5000};
		{module_var, param_value, param_max} = {32'sd0, 32'sd500, 32'd1000};
		{speed_rpm, active_current, reactive_current} = {16'sd1500, 16'sd100, 16'sd200};
		{output_voltage, max_speed, rated_current, max_bus_voltage} = {16'd400, 16'd3000, 16'd900, 16'd800};
		repeat (16) @(posedge clk);
		rst_b <= 1;
		rd_reg(8'h08);
		chk("scale", d, 32'h64);
		rd_reg(8'h10);
		chk("minv", d, 32'hffffec78);
		rd_reg(8'h24);
		chk("unmapped", d, 32'h0);
		wr_reg(8'h18, 32'd1500);
		run(32'h301, 0, 16'd7450);
		run(32'h311, 0, 16'd1500);
		run(32'h321, 0, 16'd10000);
		run(32'h331, 5000, 16'd10000);
		run(32'h331, -5000, 16'd1500);
		run(32'h331, 20000, 16'd10000);
		run(32'h331, -20000, 16'd0);
		for (i = 0; i < 4; i++) begin
			run({i[1:0], 8'h31}, 0, 16'd5750);
			chk("mode", dac_mode, i);
			chk("slow", gap > 300, 1);
		end
		wr_reg(8'h04, 32'h1505);
		run(32'h341, 0, 16'd5000);
		chk("menu", {param_menu, param_num}, 16'h1505);
		wr_reg(8'h08, 32'd50);
		run(32'h341, 0, 16'd2500);
		wr_reg(8'h04, 32'h1534);
		rd_reg(8'h1c);
		chk("selerr", d[3], 1);
		chk("menu", {param_menu, param_num}, 16'h1505);
		run(32'h351, 0, 16'd7025);
		chk("slow", gap > 300, 1);
		run(32'h381, 0, 16'd5784);
		run(32'h251, 0, 16'd5000);
		chk("fast", gap < 200, 1);
		run(32'h261, 0, 16'd500);
		run(32'h271, 0, 16'd1000);
		run(32'h281, 0, 16'd250);
		stall <= 1;
		for (i = 0; i < 1000; i++) begin
			rd_reg(8'h1c);
			if (d[12:8] == 5'h10)
				break;
		end
		chk("level", d[12:8], 5'h10);
		stall <= 0;
		for (i = 0; i < 18; i++) begin
			take;
			chk("drain", x, 16'd250);
		end
		wr_reg(8'h00, 32'h250);
		repeat (3) @(posedge clk);
		k = 0;
		repeat (600) @(posedge clk) k += dac_valid;
		chk("quiet", k, 0);
		conclude;
	end
endmodule // aos_scaler_test
bind aos_scaler aos_scaler_monitor u_mon (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
	.param_menu, .param_num, .dac_valid, .dac_ready, .dac_data, .dac_mode);
